// ===== acr_bank.sv
// Page-zero amplifier configuration register bank with fault and shutdown.
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_bank import acr_pkg::*; #(
	parameter int unsigned SD_CYC0   = `ACR_US2CYC(`ACR_SD_T0_US),
	parameter int unsigned SD_CYC1   = `ACR_US2CYC(`ACR_SD_T1_US),
	parameter int unsigned SD_CYC2   = `ACR_US2CYC(`ACR_SD_T2_US),
	parameter int unsigned SD_CYC3   = `ACR_US2CYC(`ACR_SD_T3_US),
	parameter int unsigned RETRY_CYC = `ACR_US2CYC(`ACR_RETRY_US)
) (
	input  wire logic     clk_in,                   // System clock.
	input  wire logic     arst_n_in,                // Async reset, low.
	input  wire acr_req_t req_in,                   // Control bus access.
	input  wire logic     switching_audio_sync_in,  // Sync mode enabled.
	input  wire logic     overcurrent_pin_in,       // Over-current flag.
	input  wire logic     overtemp_pin_in,          // Over-temp flag.
	input  wire logic     shutdown_pin_n_in,        // Shutdown pin, low.
	input  wire logic     fault_clear_in,           // Clear held faults.
	output logic [7:0]    reg_rdata_out,            // Read data.
	output acr_cfg_t      cfg_out,                  // Configuration.
	output logic          spread_spectrum_on_out,   // Dithering active.
	output logic          irq_pin_pullup_en_out,    // Pull-up enable.
	output logic          volume_ramp_en_out,       // Volume ramping.
	output logic          target_address_redetect_out, // Re-detect pulse.
	output logic          amp_shutdown_out,         // Stage shut down.
	output logic          oc_shutdown_out,          // Over-current off.
	output logic          ot_shutdown_out           // Over-temp off.
);

	acr_bank_st_t q;
	acr_bank_st_t n;
	logic         sd_off;
	logic         oc_off;
	logic         ot_off;

	// Configuration bytes are visible only while page zero is selected.
	function automatic logic cfg_hit(input logic [7:0] page,
			input logic [7:0] addr, input logic [7:0] target);
		cfg_hit = (page == `ACR_PAGE_CFG) && (addr == target);
	endfunction

	always_comb begin
		n         = q;
		n.oc_sync = {q.oc_sync[0], overcurrent_pin_in};
		n.ot_sync = {q.ot_sync[0], overtemp_pin_in};
		n.sd_sync = {q.sd_sync[0], shutdown_pin_n_in};
		n.rdata   = 8'h00;
		n.shut[`ACR_REDET_BIT] = 1'b0;
		if (req_in.wr) begin
			if (req_in.addr == `ACR_ADDR_PAGE) begin
				n.page = req_in.wdata;
			end
			if (cfg_hit(q.page, req_in.addr, `ACR_ADDR_STAGE)) begin
				n.stage = req_in.wdata;
			end
			if (cfg_hit(q.page, req_in.addr, `ACR_ADDR_SUPPLY)) begin
				n.supply = req_in.wdata;
			end
			if (cfg_hit(q.page, req_in.addr, `ACR_ADDR_FOLD)) begin
				n.fold = req_in.wdata;
			end
			if (cfg_hit(q.page, req_in.addr, `ACR_ADDR_RETRY)) begin
				n.retry = req_in.wdata;
			end
			// A write landing with the self clear keeps the bit set.
			if (cfg_hit(q.page, req_in.addr, `ACR_ADDR_SHUT)) begin
				n.shut = req_in.wdata;
			end
		end
		n.redetect = req_in.wr && req_in.wdata[`ACR_REDET_BIT] &&
			cfg_hit(q.page, req_in.addr, `ACR_ADDR_SHUT);
		if (req_in.rd) begin
			if (req_in.addr == `ACR_ADDR_PAGE) begin
				n.rdata = q.page;
			end else if (cfg_hit(q.page, req_in.addr, `ACR_ADDR_STAGE)) begin
				n.rdata = q.stage;
			end else if (cfg_hit(q.page, req_in.addr, `ACR_ADDR_SUPPLY)) begin
				n.rdata = q.supply;
			end else if (cfg_hit(q.page, req_in.addr, `ACR_ADDR_FOLD)) begin
				n.rdata = q.fold;
			end else if (cfg_hit(q.page, req_in.addr, `ACR_ADDR_RETRY)) begin
				n.rdata = q.retry;
			end else if (cfg_hit(q.page, req_in.addr, `ACR_ADDR_SHUT)) begin
				n.rdata = q.shut;
			end
		end
		n.ss_on = n.supply[`ACR_SS_BIT] & ~switching_audio_sync_in;
		n.ramp_en = (n.shut[`ACR_RAMP_MSB:`ACR_RAMP_LSB] ==
			`ACR_RAMP_ON);
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q <= '{page: `ACR_RST_PAGE, stage: `ACR_RST_STAGE,
				supply: `ACR_RST_SUPPLY, fold: `ACR_RST_FOLD,
				retry: `ACR_RST_RETRY, shut: `ACR_RST_SHUT,
				rdata: 8'h00, ss_on: 1'b1, ramp_en: 1'b1,
				redetect: 1'b0, oc_sync: 2'h0, ot_sync: 2'h0,
				sd_sync: 2'h3};
		end else begin
			q <= n;
		end
	end

	acr_shutdown_ctrl #(
		.SD_CYC0 (SD_CYC0),
		.SD_CYC1 (SD_CYC1),
		.SD_CYC2 (SD_CYC2),
		.SD_CYC3 (SD_CYC3)
	) u_shutdown (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.req_in    (!q.sd_sync[1]),
		.mode_in   (q.shut[`ACR_SDMODE_MSB:`ACR_SDMODE_LSB]),
		.sel_in    (q.shut[`ACR_SDSEL_MSB:`ACR_SDSEL_LSB]),
		.off_out   (sd_off)
	);

	acr_retry_ctrl #(
		.RETRY_CYC (RETRY_CYC)
	) u_oc_retry (
		.clk_in       (clk_in),
		.arst_n_in    (arst_n_in),
		.fault_in     (q.oc_sync[1]),
		.retry_en_in  (q.retry[`ACR_OCRETRY_BIT]),
		.clear_in     (fault_clear_in),
		.shutdown_out (oc_off)
	);

	acr_retry_ctrl #(
		.RETRY_CYC (RETRY_CYC)
	) u_ot_retry (
		.clk_in       (clk_in),
		.arst_n_in    (arst_n_in),
		.fault_in     (q.ot_sync[1]),
		.retry_en_in  (q.retry[`ACR_OTRETRY_BIT]),
		.clear_in     (fault_clear_in),
		.shutdown_out (ot_off)
	);

	assign reg_rdata_out               = q.rdata;
	assign spread_spectrum_on_out      = q.ss_on;
	assign irq_pin_pullup_en_out       = q.supply[`ACR_PULLUP_BIT];
	assign volume_ramp_en_out          = q.ramp_en;
	assign target_address_redetect_out = q.redetect;
	assign amp_shutdown_out            = sd_off;
	assign oc_shutdown_out             = oc_off;
	assign ot_shutdown_out             = ot_off;

	assign cfg_out.output_supply_select =
		q.stage[`ACR_SUPPLY_MSB:`ACR_SUPPLY_LSB];
	assign cfg_out.amp_level = q.stage[`ACR_LEVEL_MSB:`ACR_LEVEL_LSB];
	assign cfg_out.low_rail_source = q.supply[`ACR_LOWRAIL_BIT];
	assign cfg_out.sar_filter_corner =
		q.supply[`ACR_SAR_MSB:`ACR_SAR_LSB];
	assign cfg_out.playback_dc_block_corner =
		q.supply[`ACR_PB_MSB:`ACR_PB_LSB];
	assign cfg_out.thermal_foldback_en = q.fold[`ACR_TFB_BIT];
	assign cfg_out.record_dc_block_corner =
		q.fold[`ACR_REC_MSB:`ACR_REC_LSB];
	assign cfg_out.overcurrent_auto_retry = q.retry[`ACR_OCRETRY_BIT];
	assign cfg_out.overtemp_auto_retry = q.retry[`ACR_OTRETRY_BIT];
	assign cfg_out.post_filter_feedback_en =
		q.retry[`ACR_PFFB_BIT];
	assign cfg_out.safe_mode_en = q.retry[`ACR_SAFE_BIT];
	assign cfg_out.shutdown_behaviour =
		q.shut[`ACR_SDMODE_MSB:`ACR_SDMODE_LSB];
	assign cfg_out.shutdown_delay_sel =
		q.shut[`ACR_SDSEL_MSB:`ACR_SDSEL_LSB];
	assign cfg_out.volume_ramp_ctrl =
		q.shut[`ACR_RAMP_MSB:`ACR_RAMP_LSB];
	assign cfg_out.broadcast_address_en = q.shut[`ACR_GBL_BIT];

	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence redet_write_s;
		req_in.wr && req_in.wdata[`ACR_REDET_BIT] &&
		cfg_hit(q.page, req_in.addr, `ACR_ADDR_SHUT);
	endsequence

	sequence redet_quiet_s;
		!(req_in.wr && req_in.addr == `ACR_ADDR_SHUT);
	endsequence

	page_gate_a: assert property (
		(req_in.wr && q.page != `ACR_PAGE_CFG &&
		req_in.addr == `ACR_ADDR_STAGE) |=> $stable(q.stage))
		else $error("Write off page zero changed a register.");

	supply_select_a: assert property (
		(req_in.wr && cfg_hit(q.page, req_in.addr, `ACR_ADDR_STAGE))
		|=> cfg_out.output_supply_select ==
		$past(req_in.wdata[`ACR_SUPPLY_MSB:`ACR_SUPPLY_LSB]))
		else $error("Supply select did not follow the write.");

	sync_priority_a: assert property (
		switching_audio_sync_in |=> !spread_spectrum_on_out)
		else $error("Spread spectrum active while sync mode is on.");

	pullup_follow_a: assert property (
		(req_in.wr && cfg_hit(q.page, req_in.addr, `ACR_ADDR_SUPPLY))
		|=> irq_pin_pullup_en_out == $past(req_in.wdata[`ACR_PULLUP_BIT]))
		else $error("Pull-up enable did not follow the write.");

	redetect_clear_a: assert property (
		redet_write_s ##1 redet_quiet_s |=>
		!q.shut[`ACR_REDET_BIT] && !target_address_redetect_out)
		else $error("Re-detect bit did not clear itself.");

	redetect_pulse_a: assert property (
		redet_write_s |=> target_address_redetect_out &&
		q.shut[`ACR_REDET_BIT])
		else $error("Re-detect write gave no pulse.");

	ramp_decode_a: assert property (
		volume_ramp_en_out == (cfg_out.volume_ramp_ctrl == `ACR_RAMP_ON))
		else $error("Volume ramp enable does not match its code.");

	read_back_a: assert property (
		(req_in.rd && cfg_hit(q.page, req_in.addr, `ACR_ADDR_FOLD))
		|=> reg_rdata_out == $past(q.fold))
		else $error("Read of the foldback register returned wrong data.");

	sequence supply_write_s;
		req_in.wr && cfg_hit(q.page, req_in.addr, `ACR_ADDR_SUPPLY);
	endsequence

	sequence fold_write_s;
		req_in.wr && cfg_hit(q.page, req_in.addr, `ACR_ADDR_FOLD);
	endsequence

	sequence retry_write_s;
		req_in.wr && cfg_hit(q.page, req_in.addr, `ACR_ADDR_RETRY);
	endsequence

	sequence shut_write_s;
		req_in.wr && cfg_hit(q.page, req_in.addr, `ACR_ADDR_SHUT);
	endsequence

	page_select_a: assert property (
		(req_in.wr && req_in.addr == `ACR_ADDR_PAGE)
		|=> q.page == $past(req_in.wdata))
		else $error("Page register did not follow the write.");

	page_read_a: assert property (
		(req_in.rd && req_in.addr == `ACR_ADDR_PAGE)
		|=> reg_rdata_out == $past(q.page))
		else $error("Read of the page register returned wrong data.");

	low_rail_follow_a: assert property (
		supply_write_s |=> cfg_out.low_rail_source ==
		$past(req_in.wdata[`ACR_LOWRAIL_BIT]))
		else $error("Low rail source did not follow the write.");

	sar_corner_a: assert property (
		supply_write_s |=> cfg_out.sar_filter_corner ==
		$past(req_in.wdata[`ACR_SAR_MSB:`ACR_SAR_LSB]))
		else $error("SAR filter corner did not follow the write.");

	playback_corner_a: assert property (
		supply_write_s |=> cfg_out.playback_dc_block_corner ==
		$past(req_in.wdata[`ACR_PB_MSB:`ACR_PB_LSB]))
		else $error("Playback blocker corner did not follow the write.");

	foldback_follow_a: assert property (
		fold_write_s |=> cfg_out.thermal_foldback_en ==
		$past(req_in.wdata[`ACR_TFB_BIT]))
		else $error("Thermal foldback enable did not follow the write.");

	record_corner_a: assert property (
		fold_write_s |=> cfg_out.record_dc_block_corner ==
		$past(req_in.wdata[`ACR_REC_MSB:`ACR_REC_LSB]))
		else $error("Record blocker corner did not follow the write.");

	oc_retry_follow_a: assert property (
		retry_write_s |=> cfg_out.overcurrent_auto_retry ==
		$past(req_in.wdata[`ACR_OCRETRY_BIT]))
		else $error("Over-current retry did not follow the write.");

	ot_retry_follow_a: assert property (
		retry_write_s |=> cfg_out.overtemp_auto_retry ==
		$past(req_in.wdata[`ACR_OTRETRY_BIT]))
		else $error("Over-temperature retry did not follow the write.");

	feedback_follow_a: assert property (
		retry_write_s |=> cfg_out.post_filter_feedback_en ==
		$past(req_in.wdata[`ACR_PFFB_BIT]))
		else $error("Feedback source did not follow the write.");

	safe_mode_follow_a: assert property (
		retry_write_s |=> cfg_out.safe_mode_en ==
		$past(req_in.wdata[`ACR_SAFE_BIT]))
		else $error("Safe mode enable did not follow the write.");

	sd_mode_follow_a: assert property (
		shut_write_s |=> cfg_out.shutdown_behaviour ==
		$past(req_in.wdata[`ACR_SDMODE_MSB:`ACR_SDMODE_LSB]))
		else $error("Shutdown behaviour did not follow the write.");

	sd_delay_follow_a: assert property (
		shut_write_s |=> cfg_out.shutdown_delay_sel ==
		$past(req_in.wdata[`ACR_SDSEL_MSB:`ACR_SDSEL_LSB]))
		else $error("Shutdown delay code did not follow the write.");

	broadcast_follow_a: assert property (
		shut_write_s |=> cfg_out.broadcast_address_en ==
		$past(req_in.wdata[`ACR_GBL_BIT]))
		else $error("Broadcast address enable did not follow the write.");

endmodule

// ===== acr_cfg.svh
// Constants of the page-zero amplifier configuration register bank.
// Behaviour
// - Byte at address zero selects register page.
// - Two-bit field picks output stage supply arrangement.
// - Spread spectrum on; audio sync overrides it.
// - Bit six enables interrupt pin pull-up.
// - Bit seven picks external or internal low rail.
// - Two-bit field sets SAR filter corner.
// - Three-bit playback DC blocker corner, zero bypasses.
// - Record DC blocker uses same encoding, resets one.
// - Bit three enables thermal foldback.
// - Over-current retry bit allows timed auto restart.
// - Over-temperature retry bit allows timed auto restart.
// - Feedback bit picks output or sense pins.
// - Bit two enables safe mode.
// - Shutdown mode: after timeout or immediate.
// - Timeout code selects 2, 4, 6, 23.8 ms.
// - Volume ramp code zero enables, three disables.
// - Bit one enables broadcast bus address response.
// - Address re-detect bit self clears after use.
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

`define ACR_ADDR_PAGE     8'h00
`define ACR_PAGE_CFG      8'h00
`define ACR_ADDR_STAGE    8'h03
`define ACR_ADDR_SUPPLY   8'h04
`define ACR_ADDR_FOLD     8'h05
`define ACR_ADDR_RETRY    8'h06
`define ACR_ADDR_SHUT     8'h07

`define ACR_RST_PAGE      8'h00
`define ACR_RST_STAGE     8'h28
`define ACR_RST_SUPPLY    8'h21
`define ACR_RST_FOLD      8'h41
`define ACR_RST_RETRY     8'h00
`define ACR_RST_SHUT      8'h20

`define ACR_SUPPLY_MSB    7
`define ACR_SUPPLY_LSB    6
`define ACR_LEVEL_MSB     5
`define ACR_LEVEL_LSB     1
`define ACR_LOWRAIL_BIT   7
`define ACR_PULLUP_BIT    6
`define ACR_SS_BIT        5
`define ACR_SAR_MSB       4
`define ACR_SAR_LSB       3
`define ACR_PB_MSB        2
`define ACR_PB_LSB        0
`define ACR_TFB_BIT       3
`define ACR_REC_MSB       2
`define ACR_REC_LSB       0
`define ACR_OCRETRY_BIT   5
`define ACR_OTRETRY_BIT   4
`define ACR_PFFB_BIT      3
`define ACR_SAFE_BIT      2
`define ACR_SDMODE_MSB    7
`define ACR_SDMODE_LSB    6
`define ACR_SDSEL_MSB     5
`define ACR_SDSEL_LSB     4
`define ACR_RAMP_MSB      3
`define ACR_RAMP_LSB      2
`define ACR_GBL_BIT       1
`define ACR_REDET_BIT     0

`define ACR_SD_TIMEOUT    2'h0
`define ACR_SD_IMMEDIATE  2'h1
`define ACR_RAMP_ON       2'h0
`define ACR_RAMP_OFF      2'h3

`define ACR_CLK_MHZ       100
`define ACR_SD_T0_US      2000
`define ACR_SD_T1_US      4000
`define ACR_SD_T2_US      6000
`define ACR_SD_T3_US      23800
`define ACR_RETRY_US      1500
`define ACR_US2CYC(us)    ((us) * `ACR_CLK_MHZ)

`endif

// ===== acr_pkg.sv
// Types shared by the amplifier configuration bank modules.
package acr_pkg;

	typedef logic [21:0] acr_cnt_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} acr_req_t;

	typedef struct packed {
		logic [1:0] output_supply_select;
		logic [4:0] amp_level;
		logic       low_rail_source;
		logic [1:0] sar_filter_corner;
		logic [2:0] playback_dc_block_corner;
		logic       thermal_foldback_en;
		logic [2:0] record_dc_block_corner;
		logic       overcurrent_auto_retry;
		logic       overtemp_auto_retry;
		logic       post_filter_feedback_en;
		logic       safe_mode_en;
		logic [1:0] shutdown_behaviour;
		logic [1:0] shutdown_delay_sel;
		logic [1:0] volume_ramp_ctrl;
		logic       broadcast_address_en;
	} acr_cfg_t;

	typedef enum logic [1:0] {
		SD_RUN  = 2'b00,
		SD_WAIT = 2'b01,
		SD_OFF  = 2'b10
	} acr_sd_state_t;

	typedef enum logic [1:0] {
		RT_RUN  = 2'b00,
		RT_HOLD = 2'b01,
		RT_WAIT = 2'b10
	} acr_rt_state_t;

	typedef struct packed {
		acr_sd_state_t st;
		acr_cnt_t      cnt;
		logic          off;
	} acr_sd_st_t;

	typedef struct packed {
		acr_rt_state_t st;
		acr_cnt_t      cnt;
		logic          shut;
	} acr_rt_st_t;

	typedef struct packed {
		logic [7:0] page;
		logic [7:0] stage;
		logic [7:0] supply;
		logic [7:0] fold;
		logic [7:0] retry;
		logic [7:0] shut;
		logic [7:0] rdata;
		logic       ss_on;
		logic       ramp_en;
		logic       redetect;
		logic [1:0] oc_sync;
		logic [1:0] ot_sync;
		logic [1:0] sd_sync;
	} acr_bank_st_t;

endpackage

// ===== acr_shutdown_ctrl.sv
// Shutdown sequencer: timed or immediate power-off on a shutdown request.
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_shutdown_ctrl import acr_pkg::*; #(
	parameter int unsigned SD_CYC0 = `ACR_US2CYC(`ACR_SD_T0_US),
	parameter int unsigned SD_CYC1 = `ACR_US2CYC(`ACR_SD_T1_US),
	parameter int unsigned SD_CYC2 = `ACR_US2CYC(`ACR_SD_T2_US),
	parameter int unsigned SD_CYC3 = `ACR_US2CYC(`ACR_SD_T3_US)
) (
	input  wire logic       clk_in,     // System clock.
	input  wire logic       arst_n_in,  // Asynchronous reset, active low.
	input  wire logic       req_in,     // Shutdown requested, level.
	input  wire logic [1:0] mode_in,    // Shutdown behaviour code.
	input  wire logic [1:0] sel_in,     // Shutdown delay code.
	output logic            off_out     // Output stage powered off.
);

	acr_sd_st_t q;
	acr_sd_st_t n;

	function automatic acr_cnt_t delay_cyc(input logic [1:0] sel);
		unique case (sel)
			2'h0: delay_cyc = acr_cnt_t'(SD_CYC0);
			2'h1: delay_cyc = acr_cnt_t'(SD_CYC1);
			2'h2: delay_cyc = acr_cnt_t'(SD_CYC2);
			2'h3: delay_cyc = acr_cnt_t'(SD_CYC3);
		endcase
	endfunction

	always_comb begin
		n = q;
		unique case (q.st)
			SD_RUN: begin
				n.cnt = '0;
				if (req_in && mode_in == `ACR_SD_IMMEDIATE) begin
					n.st  = SD_OFF;
					n.off = 1'b1;
				end else if (req_in) begin
					n.st = SD_WAIT;
				end
			end
			SD_WAIT: begin
				if (!req_in) begin
					n.st = SD_RUN;
				end else if (mode_in == `ACR_SD_IMMEDIATE ||
						q.cnt == delay_cyc(sel_in) - 22'h1) begin
					n.st  = SD_OFF;
					n.off = 1'b1;
				end else begin
					n.cnt = q.cnt + 22'h1;
				end
			end
			SD_OFF: begin
				if (!req_in) begin
					n.st  = SD_RUN;
					n.off = 1'b0;
				end
			end
			default: begin
				n.st  = SD_OFF;
				n.off = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q <= '{st: SD_RUN, cnt: '0, off: 1'b0};
		end else begin
			q <= n;
		end
	end

	assign off_out = q.off;

	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	immediate_off_a: assert property (
		(q.st == SD_RUN && req_in && mode_in == `ACR_SD_IMMEDIATE)
		|=> off_out)
		else $error("Immediate shutdown did not power off.");

	timeout_count_a: assert property (
		($rose(off_out) && $past(q.st) == SD_WAIT &&
		$past(mode_in) == `ACR_SD_TIMEOUT)
		|-> $past(q.cnt) == delay_cyc($past(sel_in)) - 22'h1)
		else $error("Timed shutdown fired at the wrong count.");

endmodule

// ===== acr_retry_ctrl.sv
// Fault shutdown latch with optional timed automatic retry.
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_retry_ctrl import acr_pkg::*; #(
	parameter int unsigned RETRY_CYC = `ACR_US2CYC(`ACR_RETRY_US)
) (
	input  wire logic clk_in,       // System clock.
	input  wire logic arst_n_in,    // Asynchronous reset, active low.
	input  wire logic fault_in,     // Synchronised fault level.
	input  wire logic retry_en_in,  // Automatic retry allowed.
	input  wire logic clear_in,     // Manual fault clear pulse.
	output logic      shutdown_out  // Shut down by this fault.
);

	acr_rt_st_t q;
	acr_rt_st_t n;

	always_comb begin
		n = q;
		unique case (q.st)
			RT_RUN: begin
				n.cnt = '0;
				if (fault_in) begin
					n.st   = RT_HOLD;
					n.shut = 1'b1;
				end
			end
			RT_HOLD: begin
				n.cnt = '0;
				if (!fault_in && retry_en_in) begin
					n.st = RT_WAIT;
				end else if (!fault_in && clear_in) begin
					n.st   = RT_RUN;
					n.shut = 1'b0;
				end
			end
			RT_WAIT: begin
				if (fault_in || !retry_en_in) begin
					n.st  = RT_HOLD;
				end else if (q.cnt == acr_cnt_t'(RETRY_CYC - 1)) begin
					n.st   = RT_RUN;
					n.shut = 1'b0;
				end else begin
					n.cnt = q.cnt + 22'h1;
				end
			end
			default: begin
				n.st   = RT_HOLD;
				n.shut = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q <= '{st: RT_RUN, cnt: '0, shut: 1'b0};
		end else begin
			q <= n;
		end
	end

	assign shutdown_out = q.shut;

	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	no_retry_hold_a: assert property (
		(q.st == RT_HOLD && !retry_en_in && !clear_in) |=> shutdown_out)
		else $error("Fault shutdown released without retry enabled.");

	retry_timer_a: assert property (
		($fell(shutdown_out) && !$past(clear_in))
		|-> $past(q.cnt) == acr_cnt_t'(RETRY_CYC - 1))
		else $error("Automatic retry did not wait for the timer.");

endmodule

// ===== acr_host_model.sv
// Host model issuing byte accesses to the configuration bank.
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_host_model import acr_pkg::*; (
	input  wire logic       clk_in,    // System clock.
	input  wire logic [7:0] rdata_in,  // Read data from the bank.
	output acr_req_t        req_out    // Byte access request.
);
	initial begin
		req_out = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, wdata: 8'hff};
	end

	// Released lines show the inverse of the last value, never a stale copy.
	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_in);
		req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
		@(posedge clk_in);
		req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
		#1;
		d = rdata_in;
	endtask

	// The bank lives on page zero, so the host selects it first.
	task automatic sel_page0();
		wr_byte(`ACR_ADDR_PAGE, `ACR_PAGE_CFG);
	endtask
endmodule

// ===== acr_bank_tb.sv
// Self-checking testbench of the configuration register bank.
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_bank_tb import acr_pkg::*; ;
	localparam int unsigned RT = 10;
	localparam int unsigned SDC [4] = '{4, 8, 12, 20};
	logic        clk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	acr_req_t    req;
	logic        sync = 1'b0;
	logic        oc_pin = 1'b0;
	logic        ot_pin = 1'b0;
	logic        pin_n = 1'b1;
	logic        fclr = 1'b0;
	logic [7:0]  rdata;
	acr_cfg_t    cfg;
	logic        ss_on, pu_en, ramp_en, redet, amp_off, oc_off, ot_off;
	logic [7:0]  rd;
	logic [1:0]  sel = 2'h0;
	logic        watch;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cyc = 0;
	logic [7:0]  adr [5] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
	logic [7:0]  rst [5] = '{8'h28, 8'h21, 8'h41, 8'h00, 8'h20};
	// Patterns keep reserved bits at their reset values.
	logic [7:0]  pat [5] = '{8'hc2, 8'h9e, 8'h4e, 8'h3c, 8'h5e};

	always #5 clk_in = ~clk_in;

	acr_host_model i_host (
		.clk_in   (clk_in),
		.rdata_in (rdata),
		.req_out  (req)
	);

	acr_bank #(
		.SD_CYC0(4), .SD_CYC1(8), .SD_CYC2(12), .SD_CYC3(20), .RETRY_CYC(RT)
	) i_dut (
		.clk_in                      (clk_in),
		.arst_n_in                   (arst_n_in),
		.req_in                      (req),
		.switching_audio_sync_in     (sync),
		.overcurrent_pin_in          (oc_pin),
		.overtemp_pin_in             (ot_pin),
		.shutdown_pin_n_in           (pin_n),
		.fault_clear_in              (fclr),
		.reg_rdata_out               (rdata),
		.cfg_out                     (cfg),
		.spread_spectrum_on_out      (ss_on),
		.irq_pin_pullup_en_out       (pu_en),
		.volume_ramp_en_out          (ramp_en),
		.target_address_redetect_out (redet),
		.amp_shutdown_out            (amp_off),
		.oc_shutdown_out             (oc_off),
		.ot_shutdown_out             (ot_off)
	);

	assign watch = (sel == 2'h0) ? amp_off : (sel == 2'h1) ? oc_off : ot_off;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons=%0d errors=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic wait_val(input logic v, input int lim);
		int n;
		n = 0;
		while (watch !== v && n < lim) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		check(8'(watch), 8'(v));
	endtask

	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			error_cnt++;
			finish_test();
		end
	end

	initial begin
		repeat (3) @(posedge clk_in);
		arst_n_in <= 1'b1;
		i_host.rd_byte(8'h00, rd);
		check(rd, 8'h00);
		for (int i = 0; i < 5; i++) begin
			i_host.rd_byte(adr[i], rd);
			check(rd, rst[i]);
		end
		check(8'(ss_on), 8'h01);
		check(8'(ramp_en), 8'h01);
		check(8'(pu_en), 8'h00);
		i_host.sel_page0();
		for (int i = 0; i < 5; i++) begin
			i_host.wr_byte(adr[i], pat[i]);
		end
		#1;
		check(8'(cfg.output_supply_select), 8'h03);
		check(8'(cfg.amp_level), 8'h01);
		check(8'(cfg.low_rail_source), 8'h01);
		check(8'(cfg.sar_filter_corner), 8'h03);
		check(8'(cfg.playback_dc_block_corner), 8'h06);
		check(8'(cfg.thermal_foldback_en), 8'h01);
		check(8'(cfg.record_dc_block_corner), 8'h06);
		check(8'(cfg.overcurrent_auto_retry), 8'h01);
		check(8'(cfg.overtemp_auto_retry), 8'h01);
		check(8'(cfg.post_filter_feedback_en), 8'h01);
		check(8'(cfg.safe_mode_en), 8'h01);
		check(8'(cfg.shutdown_behaviour), 8'h01);
		check(8'(cfg.shutdown_delay_sel), 8'h01);
		check(8'(cfg.volume_ramp_ctrl), 8'h03);
		check(8'(ramp_en), 8'h00);
		check(8'(cfg.broadcast_address_en), 8'h01);
		check(8'(ss_on), 8'h00);
		for (int i = 0; i < 5; i++) begin
			i_host.rd_byte(adr[i], rd);
			check(rd, pat[i]);
		end
		// A foreign page hides the bank for reads and writes alike.
		i_host.wr_byte(8'h00, 8'h01);
		i_host.wr_byte(8'h03, 8'h28);
		i_host.rd_byte(8'h03, rd);
		check(rd, 8'h00);
		i_host.rd_byte(8'h00, rd);
		check(rd, 8'h01);
		i_host.sel_page0();
		i_host.rd_byte(8'h03, rd);
		check(rd, 8'hc2);
		i_host.rd_byte(8'h02, rd);
		check(rd, 8'h00);
		i_host.wr_byte(8'h04, 8'h61);
		#1;
		check(8'(pu_en), 8'h01);
		check(8'(ss_on), 8'h01);
		@(posedge clk_in) sync <= 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
		check(8'(ss_on), 8'h00);
		@(posedge clk_in) sync <= 1'b0;
		i_host.wr_byte(8'h07, 8'h21);
		#1;
		check(8'(redet), 8'h01);
		@(posedge clk_in);
		#1;
		check(8'(redet), 8'h00);
		i_host.rd_byte(8'h07, rd);
		check(rd, 8'h20);
		check(8'(ramp_en), 8'h01);
		sel = 2'h0;
		for (int c = 0; c < 4; c++) begin
			i_host.wr_byte(8'h07, {2'h0, 2'(c), 4'h0});
			@(posedge clk_in) pin_n <= 1'b0;
			repeat (SDC[c] + 2) @(posedge clk_in);
			#1;
			check(8'(amp_off), 8'h00);
			wait_val(1'b1, 1);
			@(posedge clk_in) pin_n <= 1'b1;
			wait_val(1'b0, 5);
		end
		i_host.wr_byte(8'h07, 8'h40);
		@(posedge clk_in) pin_n <= 1'b0;
		repeat (4) @(posedge clk_in);
		#1;
		check(8'(amp_off), 8'h01);
		@(posedge clk_in) pin_n <= 1'b1;
		wait_val(1'b0, 5);
		for (int f = 0; f < 2; f++) begin
			sel = 2'(f + 1);
			i_host.wr_byte(8'h06, 8'h30);
			@(posedge clk_in) {ot_pin, oc_pin} <= f ? 2'b10 : 2'b01;
			wait_val(1'b1, 5);
			@(posedge clk_in) {ot_pin, oc_pin} <= 2'b00;
			repeat (RT + 2) @(posedge clk_in);
			#1;
			check(8'(watch), 8'h01);
			wait_val(1'b0, 1);
			i_host.wr_byte(8'h06, 8'h00);
			@(posedge clk_in) {ot_pin, oc_pin} <= f ? 2'b10 : 2'b01;
			wait_val(1'b1, 5);
			@(posedge clk_in) {ot_pin, oc_pin} <= 2'b00;
			repeat (RT + 20) @(posedge clk_in);
			#1;
			check(8'(watch), 8'h01);
			@(posedge clk_in) fclr <= 1'b1;
			@(posedge clk_in) fclr <= 1'b0;
			wait_val(1'b0, 4);
		end
		finish_test();
	end
endmodule
